// *** logic/csd_top.v ***
// chip-select decode, configuration registers and cycle sequencer
// assumes an apb master for registers and a memory-cycle master that
// holds its request steady until the cycle's last acknowledge
//
// Overview of operation
// - decode sizes from 4K up to 4G
// - reset clears all; cs0 write-protect, valid set
// - base field is address bits 31 to 12
// - match: masked address equals masked base
// - only 28 address bits are driven
// - dram type used only in dram mode
// - mux select picks internal or external mux
// - global mux bits force external mux
// - mux mode picks 10 or 8 column
// - idle bit adds one recovery cycle
// - dram select gates dram versus static bits
// - no burst bit: single cycles only
// - burst bit: first wait, then burst timing
// - write protect aborts writes at once
// - decode only while valid bit set
// - cycles last two clocks plus wait
// - burst beats last one to four clocks
// - burst capped at 2, 4, 8, 16
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "csd_map.vh"

module csd_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire mem_req,
  input wire [31:0] mem_addr,
  input wire mem_write,
  input wire mem_burst,
  input wire burst_last_signal,
  output wire mem_ack,
  output wire mem_last,
  output wire mem_abort,
  output wire mem_miss,
  output reg [4:0] cs_n,
  output reg [27:0] mem_addr_out,
  output reg dram_mode,
  output reg [1:0] dram_type_field,
  output reg dram_type_rsvd,
  output reg int_mux_en,
  output reg mux_mode_bit,
  output reg mux_control_pin,
  output reg static_read_sync_bit,
  output reg static_write_sync_bit
);

  localparam ST_IDLE = 2'h0;
  localparam ST_ACC = 2'h1;
  localparam ST_RCV = 2'h2;

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  // byte-lane merge for apb writes
  function [31:0] csd_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer b;
    begin
      csd_merge = old_val;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          csd_merge[b*8 +: 8] = new_val[b*8 +: 8];
        end
      end
    end
  endfunction

  // address match of one chip select
  function csd_hit;
    input [31:0] addr;
    input [31:0] bar;
    input [31:0] opt;
    reg [31:0] mask_w;
    reg [31:0] base_w;
    begin
      mask_w = {opt[`CSD_MASK_HI:`CSD_MASK_LO], 12'h000};
      base_w = {bar[`CSD_BASE_HI:`CSD_BASE_LO], 12'h000};
      csd_hit = bar[`CSD_V_BIT] &&
        ((addr & mask_w) == (base_w & mask_w));
    end
  endfunction

  // ------------------------------------------------------------
  // apb access qualifiers
  // ------------------------------------------------------------
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite;

  // zero wait states: data is prepared in the setup cycle
  assign pready = 1'b1;

  // ------------------------------------------------------------
  // per chip-select registers
  // ------------------------------------------------------------
  wire [32*`CSD_NUM_CS-1:0] bar_w;
  wire [32*`CSD_NUM_CS-1:0] opt_w;
  wire [`CSD_NUM_CS-1:0] hit_w;

  genvar g;
  generate
    for (g = 0; g < `CSD_NUM_CS; g = g + 1) begin : cs
      localparam [31:0] BAR_ADDR =
        `CSD_BAR0_ADDR + `CSD_CS_STRIDE * g;
      localparam [31:0] OPT_ADDR = BAR_ADDR + `CSD_OPT_OFS;
      localparam [31:0] BAR_RST =
        (g == 0) ? `CSD_BAR0_RST : `CSD_BAR_RST;
      reg [31:0] bar_reg;
      reg [31:0] opt_reg;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          bar_reg <= BAR_RST;
          opt_reg <= `CSD_OPT_RST;
        end else if (apb_wr) begin
          if (paddr == BAR_ADDR) begin
            bar_reg <= csd_merge(bar_reg, pwdata, pstrb);
          end else if (paddr == OPT_ADDR) begin
            opt_reg <= csd_merge(opt_reg, pwdata, pstrb);
          end
        end
      end

      assign bar_w[g*32 +: 32] = bar_reg;
      assign opt_w[g*32 +: 32] = opt_reg;
      // each decode is evaluated on its own
      assign hit_w[g] = csd_hit(mem_addr, bar_reg, opt_reg);
    end
  endgenerate

  // ------------------------------------------------------------
  // global configuration register
  // ------------------------------------------------------------
  reg [31:0] gcfg_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gcfg_reg <= `CSD_GCFG_RST;
    end else if (apb_wr && paddr == `CSD_GCFG_ADDR) begin
      gcfg_reg <= csd_merge(gcfg_reg, pwdata, pstrb) &
        `CSD_GCFG_WMASK;
    end
  end

  wire g_ext_mux = gcfg_reg[`CSD_GMUX_BIT] ||
    gcfg_reg[`CSD_GMUX2_BIT];

  // ------------------------------------------------------------
  // sequencer state
  // ------------------------------------------------------------
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [2:0] cs_idx_reg;
  reg [4:0] beat_reg;
  reg [31:0] cur_bar_reg;
  reg [31:0] cur_opt_reg;

  // ------------------------------------------------------------
  // register read path
  // ------------------------------------------------------------
  wire [31:0] stat_w = {22'h000000, state_reg == ST_RCV,
    beat_reg, cs_idx_reg, state_reg != ST_IDLE};

  reg [31:0] rd_next;
  reg err_next;
  integer r;

  always @* begin
    rd_next = 32'h00000000;
    err_next = 1'b0;
    if (paddr == `CSD_GCFG_ADDR) begin
      rd_next = gcfg_reg;
    end else if (paddr == `CSD_STAT_ADDR) begin
      rd_next = pwrite ? 32'h00000000 : stat_w;
    end else begin
      err_next = 1'b1;
      for (r = 0; r < `CSD_NUM_CS; r = r + 1) begin
        if (paddr == `CSD_BAR0_ADDR + `CSD_CS_STRIDE * r) begin
          rd_next = bar_w[r*32 +: 32];
          err_next = 1'b0;
        end else if (paddr == `CSD_BAR0_ADDR +
            `CSD_CS_STRIDE * r + `CSD_OPT_OFS) begin
          rd_next = opt_w[r*32 +: 32];
          err_next = 1'b0;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata <= pwrite ? 32'h00000000 : rd_next;
      pslverr <= err_next;
    end
  end

  // ------------------------------------------------------------
  // chip-select selection
  // ------------------------------------------------------------
  // lowest index wins when decodes overlap
  reg any_hit;
  reg [2:0] sel_idx;
  reg [31:0] sel_bar;
  reg [31:0] sel_opt;
  integer s;

  always @* begin
    any_hit = 1'b0;
    sel_idx = 3'h0;
    sel_bar = 32'h00000000;
    sel_opt = 32'h00000000;
    for (s = `CSD_NUM_CS - 1; s >= 0; s = s - 1) begin
      if (hit_w[s]) begin
        any_hit = 1'b1;
        sel_idx = s[2:0];
        sel_bar = bar_w[s*32 +: 32];
        sel_opt = opt_w[s*32 +: 32];
      end
    end
  end

  // ------------------------------------------------------------
  // cycle start, abort and miss
  // ------------------------------------------------------------
  wire idle_req = (state_reg == ST_IDLE) && mem_req;
  wire wp_hit = mem_write && sel_bar[`CSD_WP_BIT];

  // protected writes end at once, without a memory cycle
  assign mem_abort = idle_req && any_hit && wp_hit;
  assign mem_miss = idle_req && !any_hit;
  wire start = idle_req && any_hit && !wp_hit;

  // ------------------------------------------------------------
  // access timing
  // ------------------------------------------------------------
  wire cur_burst = cur_bar_reg[`CSD_BURST_BIT];
  wire [3:0] sel_wait = sel_opt[`CSD_WAIT_HI:`CSD_WAIT_LO];
  wire [1:0] cur_burst_cycle_length = cur_opt_reg[`CSD_BURST_CYCLE_LENGTH_HI:`CSD_BURST_CYCLE_LENGTH_LO];
  wire [1:0] cur_burst_length_cap =
    cur_opt_reg[`CSD_BURST_LENGTH_CAP_HI:`CSD_BURST_LENGTH_CAP_LO];

  wire [4:0] first_len = `CSD_MIN_CYC + {1'b0, sel_wait};
  wire [4:0] beat_len = `CSD_BURST_CYCLE_LENGTH_BASE + {3'h0, cur_burst_cycle_length};
  wire [4:0] beat_cap = `CSD_BEAT_BASE << cur_burst_length_cap;
  wire [4:0] beat_inc = beat_reg + 5'h01;

  wire acc_end;

  // burst goes on only if allowed, wanted and under the cap
  wire cont = cur_burst && mem_burst &&
    burst_last_signal &&
    (beat_inc < beat_cap);

  wire beat_load = (state_reg == ST_ACC) && acc_end && cont;
  wire tmr_load = start || beat_load;
  wire [4:0] tmr_val = start ? first_len : beat_len;

  csd_cycle_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(tmr_load),
    .load_val(tmr_val),
    .expire(acc_end),
    .busy()
  );

  assign mem_ack = (state_reg == ST_ACC) && acc_end;
  assign mem_last = mem_ack && !cont;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_ACC;
        end
      end
      ST_ACC: begin
        if (mem_last) begin
          // recovery clock keeps the chip select idle
          if (cur_bar_reg[`CSD_IDLE_BIT]) begin
            state_next = ST_RCV;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_RCV: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      cs_idx_reg <= 3'h0;
      beat_reg <= 5'h00;
      cur_bar_reg <= 32'h00000000;
      cur_opt_reg <= 32'h00000000;
      cs_n <= 5'h1f;
    end else begin
      state_reg <= state_next;
      if (start) begin
        // config is frozen for the whole cycle
        cs_idx_reg <= sel_idx;
        cur_bar_reg <= sel_bar;
        cur_opt_reg <= sel_opt;
        beat_reg <= 5'h00;
        cs_n <= ~(5'h01 << sel_idx);
      end else if (beat_load) begin
        beat_reg <= beat_inc;
      end else if (mem_last) begin
        cs_n <= 5'h1f;
      end
    end
  end

  // ------------------------------------------------------------
  // memory-side outputs
  // ------------------------------------------------------------
  wire sel_dram = sel_bar[`CSD_DRAM_SELECT_BIT_BIT];
  wire sel_ext = g_ext_mux || sel_bar[`CSD_MUXS_BIT];
  wire cur_dram = cur_bar_reg[`CSD_DRAM_SELECT_BIT_BIT];
  wire cur_ext = g_ext_mux || cur_bar_reg[`CSD_MUXS_BIT];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr_out <= 28'h0000000;
      dram_mode <= 1'b0;
      dram_type_field <= 2'h0;
      dram_type_rsvd <= 1'b0;
      int_mux_en <= 1'b0;
      mux_mode_bit <= 1'b0;
      static_read_sync_bit <= 1'b0;
      static_write_sync_bit <= 1'b0;
    end else if (start) begin
      mem_addr_out <= mem_addr[27:0];
      dram_mode <= sel_dram;
      dram_type_field <= sel_dram ?
        sel_bar[`CSD_DTYPE_HI:`CSD_DTYPE_LO] : 2'h0;
      dram_type_rsvd <= sel_dram &&
        sel_bar[`CSD_DTYPE_HI:`CSD_DTYPE_LO] == `CSD_DT_RSVD;
      int_mux_en <= sel_dram && !sel_ext;
      mux_mode_bit <= sel_dram && sel_bar[`CSD_MUXM_BIT];
      static_read_sync_bit <= !sel_dram &&
        sel_opt[`CSD_STATIC_READ_SYNC_BIT_BIT];
      static_write_sync_bit <= !sel_dram &&
        sel_opt[`CSD_STATIC_WRITE_SYNC_BIT_BIT];
    end else if (state_reg == ST_ACC) begin
      // master may advance the address between burst beats
      mem_addr_out <= mem_addr[27:0];
    end
  end

  // row address goes out first; column phase raises the pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_control_pin <= 1'b0;
    end else if (state_reg == ST_ACC && !mem_last) begin
      mux_control_pin <= cur_dram && cur_ext;
    end else begin
      mux_control_pin <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** logic/csd_map.vh ***
// constants of the chip-select decode and configuration block
// assumes byte addressing on a 32-bit bus, one aligned word per register
`ifndef CSD_MAP_VH
`define CSD_MAP_VH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define CSD_NUM_CS 5
`define CSD_GCFG_ADDR 32'hffc00000
`define CSD_STAT_ADDR 32'hffc00004
`define CSD_BAR0_ADDR 32'hffc00010
`define CSD_CS_STRIDE 32'h00000010
`define CSD_OPT_OFS 32'h00000004

// ------------------------------------------------------------
// base register fields
// ------------------------------------------------------------
`define CSD_BASE_HI 31
`define CSD_BASE_LO 12
`define CSD_DTYPE_HI 10
`define CSD_DTYPE_LO 9
`define CSD_MUXS_BIT 8
`define CSD_MUXM_BIT 7
`define CSD_IDLE_BIT 5
`define CSD_DRAM_SELECT_BIT_BIT 4
`define CSD_BURST_BIT 3
`define CSD_WP_BIT 1
`define CSD_V_BIT 0

// ------------------------------------------------------------
// option register fields
// ------------------------------------------------------------
`define CSD_MASK_HI 31
`define CSD_MASK_LO 12
`define CSD_WAIT_HI 11
`define CSD_WAIT_LO 8
`define CSD_BURST_CYCLE_LENGTH_HI 7
`define CSD_BURST_CYCLE_LENGTH_LO 6
`define CSD_BURST_LENGTH_CAP_HI 5
`define CSD_BURST_LENGTH_CAP_LO 4
`define CSD_STATIC_READ_SYNC_BIT_BIT 1
`define CSD_STATIC_WRITE_SYNC_BIT_BIT 0

// ------------------------------------------------------------
// global configuration and status fields
// ------------------------------------------------------------
`define CSD_GMUX_BIT 20
`define CSD_GMUX2_BIT 16
`define CSD_GCFG_WMASK 32'h00110000
`define CSD_STAT_BUSY_BIT 0
`define CSD_STAT_RCV_BIT 9

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CSD_BAR_RST 32'h00000000
`define CSD_BAR0_RST 32'h00000003
`define CSD_OPT_RST 32'h00000000
`define CSD_GCFG_RST 32'h00000000

// ------------------------------------------------------------
// timing and encodings
// ------------------------------------------------------------
`define CSD_MIN_CYC 5'h02
`define CSD_BURST_CYCLE_LENGTH_BASE 5'h01
`define CSD_BEAT_BASE 5'h02
`define CSD_DT_RSVD 2'h3

`endif

// *** logic/csd_cycle_timer.v ***
// down counter that times one memory access in bus clocks
// assumes load is a one-cycle pulse from the cycle sequencer
`timescale 1ns/100ps
`default_nettype none

module csd_cycle_timer (
  input wire pclk,
  input wire presetn,
  input wire load,
  input wire [4:0] load_val,
  output wire expire,
  output wire busy
);

  reg [4:0] count_reg;
  reg [4:0] count_next;

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  // a load of n makes expire high in the n-th cycle after it
  always @* begin
    count_next = count_reg;
    if (load) begin
      count_next = load_val;
    end else if (count_reg != 5'h00) begin
      count_next = count_reg - 5'h01;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 5'h00;
    end else begin
      count_reg <= count_next;
    end
  end

  assign expire = (count_reg == 5'h01);
  assign busy = (count_reg != 5'h00);

endmodule

`default_nettype wire

// *** testbench/csd_top_sva.sv ***
// assertions on the memory-cycle outputs of csd_top
// assumes one clock pclk and asynchronous active-low presetn
`timescale 1ns/100ps
`default_nettype none
module csd_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] mem_addr,
  input wire logic mem_write,
  input wire logic mem_ack,
  input wire logic mem_last,
  input wire logic mem_abort,
  input wire logic mem_miss,
  input wire logic [4:0] cs_n,
  input wire logic [27:0] mem_addr_out,
  input wire logic dram_mode,
  input wire logic [1:0] dram_type_field,
  input wire logic dram_type_rsvd,
  input wire logic int_mux_en,
  input wire logic mux_mode_bit,
  input wire logic mux_control_pin
);
  wire cs_act = cs_n != 5'h1f;
  wire [27:0] addr_lo = mem_addr[27:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // cycle framing
  // ----------------------------------------
  sequence s_open;
    $rose(cs_act);
  endsequence
  sequence s_close;
    mem_last ##1 !cs_act;
  endsequence
  first_wait_a: assert property (s_open |-> !mem_ack)
    else $error("ack in first select cycle");
  cs_release_a: assert property (mem_last |-> s_close)
    else $error("select held after last beat");
  last_ack_a: assert property (mem_last |-> mem_ack)
    else $error("last without ack");
  abort_write_a: assert property (mem_abort |-> mem_write && !cs_act ##1 !cs_act)
    else $error("abort on read or with select");
  miss_quiet_a: assert property (mem_miss |-> !mem_abort ##1 !cs_act)
    else $error("select after miss");
  one_cs_a: assert property (cs_act |-> $onehot(~cs_n))
    else $error("several selects low");
  addr_drive_a: assert property (s_open |-> mem_addr_out == $past(addr_lo))
    else $error("address out not low 28 bits");
  static_gate_a: assert property (!dram_mode |-> dram_type_field == 2'h0
    && !int_mux_en && !mux_mode_bit && !mux_control_pin)
    else $error("dram fields used in static mode");
  type_rsvd_a: assert property (dram_type_rsvd |-> dram_mode
    && dram_type_field == 2'h3)
    else $error("reserved flag without type 11");
endmodule
bind csd_top csd_chk u_chk (.pclk, .presetn, .mem_addr, .mem_write,
  .mem_ack, .mem_last, .mem_abort, .mem_miss, .cs_n, .mem_addr_out,
  .dram_mode, .dram_type_field, .dram_type_rsvd, .int_mux_en,
  .mux_mode_bit, .mux_control_pin);
`default_nettype wire

// *** testbench/csd_master_model.sv ***
// memory-cycle master: one request or burst per go, reports timing
// assumes go is held only to chain a second request with no gap
`timescale 1ns/100ps
`default_nettype none
module csd_master_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [31:0] req_addr,
  input wire logic req_write,
  input wire logic [4:0] want,
  input wire logic mem_ack,
  input wire logic mem_last,
  input wire logic mem_abort,
  input wire logic mem_miss,
  input wire logic [4:0] cs_n,
  input wire logic [27:0] mem_addr_out,
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic mem_write,
  output logic mem_burst,
  output logic burst_last_signal,
  output logic [7:0] nfin,
  output logic [7:0] cnt,
  output logic [7:0] beats,
  output logic abt,
  output logic mis,
  output logic [4:0] cs_cap,
  output logic [27:0] ao_cap
);
  logic [7:0] rc, rb;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req <= 1'b0;
      mem_addr <= 32'h0;
      mem_write <= 1'b0;
      mem_burst <= 1'b0;
      burst_last_signal <= 1'b0;
      nfin <= 8'h0;
    end else if (!mem_req) begin
      if (go) begin
        mem_req <= 1'b1;
        mem_addr <= req_addr;
        mem_write <= req_write;
        mem_burst <= want > 5'h01;
        burst_last_signal <= want > 5'h01;
        rc <= 8'h0;
        rb <= 8'h0;
      end
    end else begin
      rc <= rc + 8'h1;
      if (mem_ack) begin
        rb <= rb + 8'h1;
        burst_last_signal <= {3'h0, want} > rb + 8'h2;
        cs_cap <= cs_n;
        ao_cap <= mem_addr_out;
      end
      if (mem_last | mem_abort | mem_miss) begin
        nfin <= nfin + 8'h1;
        cnt <= rc + 8'h1;
        beats <= rb + {7'h0, mem_ack};
        abt <= mem_abort;
        mis <= mem_miss;
        rc <= 8'h0;
        rb <= 8'h0;
        burst_last_signal <= want > 5'h01;
        // released lines no longer show the old request
        if (!go) begin
          mem_req <= 1'b0;
          mem_addr <= ~mem_addr;
          mem_write <= ~mem_write;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/csd_top_test.sv ***
// self-checking bench for csd_top: apb registers, memory cycles
// assumes the master model drives the memory-cycle side
`timescale 1ns/100ps
`default_nettype none
`include "csd_map.vh"
module csd_top_test;
  logic pclk, presetn, psel, penable, pwrite, go, req_write, err;
  logic [31:0] paddr, pwdata, prdata, rd, req_addr, mem_addr;
  logic [3:0] pstrb;
  logic pready, pslverr, mem_req, mem_write, mem_burst, burst_last_signal;
  logic mem_ack, mem_last, mem_abort, mem_miss, abt, mis;
  logic dram_mode, dram_type_rsvd, int_mux_en, mux_mode_bit;
  logic mux_control_pin, static_read_sync_bit, static_write_sync_bit;
  logic [1:0] dram_type_field;
  logic [4:0] cs_n, want, cs_cap;
  logic [27:0] mem_addr_out, ao_cap;
  logic [7:0] nfin, cnt, beats, mcp_n;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  wire [7:0] dv = {dram_mode, dram_type_field, dram_type_rsvd, int_mux_en,
    mux_mode_bit, static_read_sync_bit, static_write_sync_bit};
  csd_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .mem_req, .mem_addr, .mem_write,
    .mem_burst, .burst_last_signal, .mem_ack, .mem_last, .mem_abort,
    .mem_miss, .cs_n, .mem_addr_out, .dram_mode, .dram_type_field,
    .dram_type_rsvd, .int_mux_en, .mux_mode_bit, .mux_control_pin,
    .static_read_sync_bit, .static_write_sync_bit);
  csd_master_model u_mst (.pclk, .presetn, .go, .req_addr, .req_write,
    .want, .mem_ack, .mem_last, .mem_abort, .mem_miss, .cs_n,
    .mem_addr_out, .mem_req, .mem_addr, .mem_write, .mem_burst,
    .burst_last_signal, .nfin, .cnt, .beats, .abt, .mis, .cs_cap, .ao_cap);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  function logic [31:0] bar(input int i);
    return `CSD_BAR0_ADDR + `CSD_CS_STRIDE * i;
  endfunction
  function logic [31:0] opt(input int i);
    return bar(i) + `CSD_OPT_OFS;
  endfunction
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [31:0] a, e);
    apb(1'b0, a, 32'h0);
    chk("prdata", rd, e);
  endtask
  task automatic cfg(input int i, input logic [31:0] o, b);
    apb(1'b1, bar(i), 32'h0);
    apb(1'b1, opt(i), o);
    apb(1'b1, bar(i), b);
  endtask
  // hold chains a second request straight after the first
  task automatic run(input logic [31:0] a, input logic w,
    input logic [4:0] n, input logic hold);
    logic [7:0] f;
    f = nfin;
    @(posedge pclk);
    req_addr <= a;
    req_write <= w;
    want <= n;
    go <= 1'b1;
    @(posedge pclk);
    if (!hold) go <= 1'b0;
    while (nfin == f) @(posedge pclk);
    go <= 1'b0;
    while (hold && nfin == f + 8'h1) @(posedge pclk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_regs;
    for (int i = 0; i < 5; i++) begin
      rdc(bar(i), i == 0 ? `CSD_BAR0_RST : `CSD_BAR_RST);
      rdc(opt(i), `CSD_OPT_RST);
    end
    apb(1'b1, bar(3), 32'hfffff7ba);
    rdc(bar(3), 32'hfffff7ba);
    apb(1'b1, opt(3), 32'h5a5a5a5a);
    rdc(opt(3), 32'h5a5a5a5a);
    apb(1'b1, bar(3), 32'h0);
    apb(1'b1, opt(3), 32'h0);
    apb(1'b1, 32'hffc00008, 32'hffffffff);
    rdc(32'hffc00008, 32'h0);
    chk("pslverr", err, 1'b1);
  endtask
  task t_abort;
    run(32'hf1234568, 1'b1, 5'h01, 1'b0);
    chk("abort", {abt, cnt}, {1'b1, 8'h01});
    run(32'hf1234568, 1'b0, 5'h01, 1'b0);
    chk("single", {abt, cnt, cs_cap}, {9'h003, 5'h1e});
    chk("addr_out", ao_cap, 28'h1234568);
    apb(1'b1, bar(0), 32'h0);
    run(32'hf1234568, 1'b0, 5'h01, 1'b0);
    chk("miss", mis, 1'b1);
  endtask
  task t_decode;
    logic [31:0] ta [5] = '{32'h005ffffc, 32'h00800000, 32'h80400000,
      32'h0d000010, 32'h02000000};
    logic [4:0] tc [5] = '{5'h1b, 5'h1f, 5'h1f, 5'h0f, 5'h1f};
    cfg(2, 32'hffc00000, 32'h00400001);
    cfg(4, 32'hf3000000, 32'h01000001);
    for (int k = 0; k < 5; k++) begin
      run(ta[k], 1'b0, 5'h01, 1'b0);
      chk("miss", mis, tc[k] == 5'h1f);
      if (tc[k] != 5'h1f) chk("cs_n", cs_cap, tc[k]);
    end
    apb(1'b1, bar(2), 32'h00400000);
    run(ta[0], 1'b0, 5'h01, 1'b0);
    chk("miss", mis, 1'b1);
    apb(1'b1, bar(4), 32'h0);
  endtask
  task t_timing;
    int w [3] = '{0, 5, 15};
    int n;
    for (int k = 0; k < 3; k++) begin
      cfg(1, w[k] << 8, 32'h1);
      run(32'h0, 1'b0, 5'h04, 1'b0);
      chk("single", {beats, cnt}, {8'h01, 8'(3 + w[k])});
    end
    for (int b = 0; b < 4; b++)
      for (int s = 0; s < 4; s++) begin
        n = 2 << s;
        cfg(1, 32'h200 | (b << 6) | (s << 4), 32'h9);
        run(32'h40, 1'b0, 5'h14, 1'b0);
        chk("beats", beats, n);
        chk("burst_cyc", cnt, 5 + (n - 1) * (b + 1));
      end
    cfg(1, 32'h30, 32'h9);
    run(32'h40, 1'b0, 5'h03, 1'b0);
    chk("early", {beats, cnt}, {8'h03, 8'h05});
    for (int i = 0; i < 2; i++) begin
      cfg(1, 32'h0, 32'h1 | (i << 5));
      run(32'h80, i[0], 5'h01, 1'b1);
      chk("recover", {abt, cnt}, {1'b0, 8'(3 + i)});
    end
  endtask
  task t_dram;
    logic [1:0] t;
    for (int i = 0; i < 4; i++) begin
      t = i[1:0];
      cfg(1, 32'h3, {21'h0, t, t[0], t[1], 7'h11});
      run(32'h100, 1'b0, 5'h01, 1'b0);
      chk("dram", dv, {1'b1, t, t == 2'h3, !t[0], t[1], 2'h0});
    end
    for (int g = 16; g < 21; g += 4) begin
      apb(1'b1, `CSD_GCFG_ADDR, 32'h1 << g);
      cfg(1, 32'h3, 32'h11);
      run(32'h100, 1'b0, 5'h01, 1'b0);
      chk("dram", dv, 8'h80);
    end
    apb(1'b1, `CSD_GCFG_ADDR, 32'h0);
    cfg(1, 32'h3, 32'h1);
    run(32'h100, 1'b0, 5'h01, 1'b0);
    chk("static", dv, 8'h03);
    chk("mux_pin", mcp_n, 8'h04);
  endtask
  // column-phase cycles of the mux control pin, one per external-mux run
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) mcp_n <= 8'h0;
    else if (mux_control_pin) mcp_n <= mcp_n + 8'h1;
  end
  // ----------------------------------------
  // clock, reset, sequence, hang limit
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      end_sim;
    end
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, go, req_write} = 5'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    req_addr = 32'h0;
    pstrb = 4'hf;
    want = 5'h01;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_abort;
    t_decode;
    t_timing;
    t_dram;
    end_sim;
  end
endmodule
`default_nettype wire
